// ===== rtl/dmr_mon_if.sv
// Conversion update bus from the monitor core to the result slots
`timescale 1ns/1ps
interface dmr_mon_if;
    import dmr_pkg::*;
    logic upd;
    dmr_tag_t chan;
    dmr_result_t data;
    modport src (output upd, output chan, output data);
    modport slot (input upd, input chan, input data);
endinterface

// ===== rtl/dmr_pkg.sv
// Types shared by the monitor result bank
package dmr_pkg;
    typedef logic [11:0] dmr_result_t;
    typedef logic [7:0] dmr_byte_t;
    typedef logic [3:0] dmr_tag_t;
endpackage

// ===== rtl/dmr_regs.svh
// Offsets, channel tags and reset values of the monitor result bank
`ifndef DMR_REGS_SVH
`define DMR_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DMR_OFF_BATT_HI 8'h56
`define DMR_OFF_BATT_LO 8'h57
`define DMR_OFF_MICB_HI 8'h58
`define DMR_OFF_MICB_LO 8'h59
`define DMR_OFF_IN1P_HI 8'h5A
`define DMR_OFF_IN1P_LO 8'h5B
`define DMR_OFF_IN1N_HI 8'h5C
`define DMR_OFF_IN1N_LO 8'h5D
`define DMR_OFF_IN2P_HI 8'h5E

// ----------------------------------------------------------------
// Channel tags, low nibble of each lower register
// ----------------------------------------------------------------
`define DMR_TAG_BATT 4'h0
`define DMR_TAG_MICB 4'h1
`define DMR_TAG_IN1P 4'h2
`define DMR_TAG_IN1N 4'h3
`define DMR_TAG_IN2P 4'h4

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DMR_UPPER_MSB 11
`define DMR_UPPER_LSB 4
`define DMR_LOWER_MSB 3
`define DMR_LOWER_LSB 0
`define DMR_RST_RESULT 12'h000
`define DMR_RD_UNMAPPED 8'h00

`endif

// ===== rtl/dmr_slot.sv
// One monitored quantity: holds the latest twelve-bit conversion
`timescale 1ns/1ps
`include "dmr_regs.svh"
module dmr_slot
    import dmr_pkg::*;
#(
    parameter dmr_tag_t TAG = `DMR_TAG_BATT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Conversion updates
    dmr_mon_if.slot mon,
    // Stored result
    output dmr_result_t result_q
);
    wire logic hit;
    assign hit = mon.upd && (mon.chan == TAG);

    // Only the monitor core writes the result
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            result_q <= `DMR_RST_RESULT;
        end else if (hit) begin
            result_q <= mon.data;
        end
    end
endmodule

// ===== rtl/dmr_top.sv
// Read-only result bank of the diagnostic successive-approximation monitor
//
// Functional notes
// - Upper bits 7-0: top eight result bits; read-only, reset zero.
// - Lower bits 7-4: bottom four result bits; read-only, reset zero.
// - Battery lower register at 0x57, resets zero, tag nibble reads 0x0.
// - Mic-bias lower register at 0x59, resets 0x01, tag nibble reads 0x1.
// - Input 1 positive lower register at 0x5B, resets 0x02, tag 0x2.
// - Input 1 negative lower register at 0x5D, resets 0x03, tag 0x3.
// - Mic-bias upper byte readable at 0x58, resets zero.
// - Input 1 positive upper byte readable at 0x5A, resets zero.
// - Input 1 negative upper byte readable at 0x5C, resets zero.
// - Input 2 positive upper byte readable at 0x5E, resets zero.
// - Battery upper byte readable at 0x56, resets zero.
`timescale 1ns/1ps
`include "dmr_regs.svh"
module dmr_top
    import dmr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Conversion results from the monitor core
    input wire logic mon_upd,
    input wire logic [3:0] mon_chan,
    input wire logic [11:0] mon_data,
    // Register read port of the control interface
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_q,
    output logic rd_ack_q
);
    // ----------------------------------------------------------------
    // Channel map
    // ----------------------------------------------------------------
    localparam int NCH = 5;
    localparam int NLO = 4;
    localparam dmr_tag_t TAGS [NCH] = '{
        `DMR_TAG_BATT, `DMR_TAG_MICB, `DMR_TAG_IN1P,
        `DMR_TAG_IN1N, `DMR_TAG_IN2P};
    localparam dmr_byte_t HI_OFF [NCH] = '{
        `DMR_OFF_BATT_HI, `DMR_OFF_MICB_HI, `DMR_OFF_IN1P_HI,
        `DMR_OFF_IN1N_HI, `DMR_OFF_IN2P_HI};
    localparam dmr_byte_t LO_OFF [NLO] = '{
        `DMR_OFF_BATT_LO, `DMR_OFF_MICB_LO, `DMR_OFF_IN1P_LO,
        `DMR_OFF_IN1N_LO};

    // Address match, shared by both byte decoders
    function automatic logic addr_hit(input dmr_byte_t a,
                                      input dmr_byte_t off);
        addr_hit = (a == off);
    endfunction

    // ----------------------------------------------------------------
    // Result slots
    // ----------------------------------------------------------------
    dmr_mon_if mon_bus ();
    assign mon_bus.upd = mon_upd;
    assign mon_bus.chan = mon_chan;
    assign mon_bus.data = mon_data;

    dmr_result_t result [NCH];
    dmr_byte_t upper [NCH];
    dmr_byte_t lower [NLO];
    logic [NCH-1:0] hit_hi;
    logic [NLO-1:0] hit_lo;
    dmr_byte_t pick_hi [NCH];
    dmr_byte_t pick_lo [NLO];

    genvar k;
    generate
        for (k = 0; k < NCH; k++) begin : g_slot
            dmr_slot #(
                .TAG(TAGS[k])
            ) u_slot (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .mon(mon_bus.slot),
                .result_q(result[k])
            );
            // Top eight bits of the stored result
            assign upper[k] =
                result[k][`DMR_UPPER_MSB:`DMR_UPPER_LSB];
            assign hit_hi[k] = addr_hit(rd_addr, HI_OFF[k]);
            assign pick_hi[k] = hit_hi[k] ? upper[k] : '0;
        end
        // Bottom nibble beside the fixed tag; input 2 has no lower register
        for (k = 0; k < NLO; k++) begin : g_lo
            assign lower[k] = {result[k][`DMR_LOWER_MSB:`DMR_LOWER_LSB],
                               TAGS[k]};
            assign hit_lo[k] =
                addr_hit(rd_addr, LO_OFF[k]);
            assign pick_lo[k] = hit_lo[k] ? lower[k] : '0;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    dmr_byte_t rd_mux;
    wire logic mapped;
    assign mapped = (|hit_hi) | (|hit_lo);

    always_comb begin
        rd_mux = `DMR_RD_UNMAPPED;
        for (int i = 0; i < NCH; i++) begin
            rd_mux = rd_mux | pick_hi[i];
        end
        for (int i = 0; i < NLO; i++) begin
            rd_mux = rd_mux | pick_lo[i];
        end
    end

    // Writes have no path here; every field is read-only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= `DMR_RD_UNMAPPED;
            rd_ack_q <= 1'b0;
        end else begin
            rd_ack_q <= rd_en;
            if (rd_en) begin
                rd_data_q <= mapped ? rd_mux : `DMR_RD_UNMAPPED;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_update(dmr_tag_t t);
        mon_upd && mon_chan == t;
    endsequence

    sequence s_read(dmr_byte_t off);
        rd_en && rd_addr == off && !mon_upd;
    endsequence

    a_upper_after_update: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_update(`DMR_TAG_MICB) ##1 s_read(`DMR_OFF_MICB_HI)
        |=> rd_ack_q && rd_data_q == $past(mon_data[11:4], 2))
        else $error("mic-bias upper byte not the last conversion");

    a_lower_after_update: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_update(`DMR_TAG_IN1P) ##1 s_read(`DMR_OFF_IN1P_LO)
        |=> rd_data_q == {$past(mon_data[3:0], 2), `DMR_TAG_IN1P})
        else $error("input 1 positive lower nibble wrong");

    a_batt_lower_tag: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        rd_en && rd_addr == `DMR_OFF_BATT_LO
        |=> rd_data_q[3:0] == `DMR_TAG_BATT
            && rd_data_q[7:4] == $past(result[0][3:0]))
        else $error("battery lower register wrong");

    a_micb_lower_tag: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        rd_en && rd_addr == `DMR_OFF_MICB_LO
        |=> rd_data_q[3:0] == `DMR_TAG_MICB)
        else $error("mic-bias channel tag wrong");

    a_in1p_lower_tag: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        rd_en && rd_addr == `DMR_OFF_IN1P_LO
        |=> rd_data_q[3:0] == `DMR_TAG_IN1P)
        else $error("input 1 positive channel tag wrong");

    a_in1n_lower_tag: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        rd_en && rd_addr == `DMR_OFF_IN1N_LO
        |=> rd_data_q[3:0] == `DMR_TAG_IN1N)
        else $error("input 1 negative channel tag wrong");

    a_micb_upper_read: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        rd_en && rd_addr == `DMR_OFF_MICB_HI
        |=> rd_data_q == $past(result[1][11:4]))
        else $error("mic-bias upper byte read wrong");

    a_in1p_upper_read: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        rd_en && rd_addr == `DMR_OFF_IN1P_HI
        |=> rd_data_q == $past(result[2][11:4]))
        else $error("input 1 positive upper byte read wrong");

    a_in1n_upper_read: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        rd_en && rd_addr == `DMR_OFF_IN1N_HI
        |=> rd_data_q == $past(result[3][11:4]))
        else $error("input 1 negative upper byte read wrong");

    a_in2p_upper_read: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_update(`DMR_TAG_IN2P) ##1 s_read(`DMR_OFF_IN2P_HI)
        |=> rd_data_q == $past(mon_data[11:4], 2))
        else $error("input 2 positive upper byte read wrong");

    a_batt_upper_read: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        rd_en && rd_addr == `DMR_OFF_BATT_HI
        |=> rd_ack_q && rd_data_q == $past(result[0][11:4]))
        else $error("battery upper byte read wrong");

    a_result_held: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !mon_upd [*2] |-> $stable(result[0]) && $stable(result[3]))
        else $error("result changed without a conversion");
endmodule

// ===== sim/dmr_top_bench.sv
// Self-checking bench for the monitor result register bank
`timescale 1ns/1ps
module dmr_top_bench;
    import dmr_pkg::*;
    // ------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic mon_upd = 1'b0;
    logic [3:0] mon_chan = 4'h0;
    logic [11:0] mon_data = 12'h000;
    logic rd_en = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rd_data_q;
    logic rd_ack_q;
    int num_errors = 0;
    int checks = 0;
    logic [7:0] d;
    dmr_result_t res [0:4];
    logic [7:0] addrs [0:11] = '{8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A,
        8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'hFF};
    dmr_result_t vals [0:4] = '{12'h9A3, 12'hB4C, 12'h5E7, 12'hC1F, 12'h7D6};

    always #4 ref_clk = ~ref_clk;

    dmr_top dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .mon_upd(mon_upd),
        .mon_chan(mon_chan),
        .mon_data(mon_data),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data_q(rd_data_q),
        .rd_ack_q(rd_ack_q)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what,
                     seen, exp);
        end
    endtask

    // Offset to expected byte: even slots upper byte, odd slots nibble+tag
    function automatic logic [7:0] exp_of(input logic [7:0] a);
        logic [7:0] k;
        k = a - 8'h56;
        if (a < 8'h56 || a > 8'h5E) return 8'h00;
        if (k[0] == 1'b0) return res[k[3:1]][11:4];
        return {res[k[3:1]][3:0], 1'b0, k[3:1]};
    endfunction

    // Called at a falling edge; leaves rd_en high for back-to-back reads
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check({7'h00, rd_ack_q}, 8'h01, "read ack");
        d = rd_data_q;
    endtask

    task automatic idle();
        rd_en = 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check({7'h00, rd_ack_q}, 8'h00, "ack drop");
    endtask

    task automatic upd(input logic [3:0] ch, input dmr_result_t d);
        mon_upd = 1'b1;
        mon_chan = ch;
        mon_data = d;
        @(posedge ref_clk);
        @(negedge ref_clk);
        if (ch < 4'h5) res[ch[2:0]] = d;
    endtask

    task automatic scan(input string nm);
        logic [7:0] d;
        logic [7:0] e;
        for (int i = 0; i < 12; i++) begin
            rd(addrs[i], d);
            e = exp_of(addrs[i]);
            if (addrs[i][0]) check(d, e, nm);
            else check(d, e, nm);
        end
        idle();
        $display("test %s done", nm);
    endtask

    task automatic do_reset();
        for (int i = 0; i < 5; i++) res[i] = 12'h000;
        nrst = 1'b0;
        // An edge under reset also clears flops that start unknown
        @(negedge ref_clk);
        check(rd_data_q, 8'h00, "data in reset");
        check({7'h00, rd_ack_q}, 8'h00, "ack in reset");
        repeat (20) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
    endtask

    task tally_and_finish();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        scan("reset values");
        for (int i = 0; i < 5; i++) upd(i[3:0], vals[i]);
        mon_upd = 1'b0;
        scan("updates");
        for (int i = 5; i < 16; i++) upd(i[3:0], 12'hFFF);
        mon_upd = 1'b0;
        scan("ignored channels");
        // Update and read in one cycle: the read sees the old value
        mon_upd = 1'b1;
        mon_chan = 4'h1;
        mon_data = 12'h3C6;
        rd_en = 1'b1;
        rd_addr = 8'h58;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check(rd_data_q, vals[1][11:4], "old on collision");
        res[1] = 12'h3C6;
        mon_upd = 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check(rd_data_q, 8'h3C, "new after collision");
        idle();
        repeat (4) @(negedge ref_clk);
        check(rd_data_q, 8'h3C, "read data held");
        $display("test collision done");
        // Update, then read the same channel on the very next edge
        upd(4'h2, 12'h6A9);
        mon_upd = 1'b0;
        rd(8'h5B, d);
        check(d, 8'h92, "in1p lower after update");
        upd(4'h4, 12'h81E);
        mon_upd = 1'b0;
        rd(8'h5E, d);
        check(d, 8'h81, "in2p upper after update");
        idle();
        $display("test update then read done");
        do_reset();
        scan("second reset");
        tally_and_finish();
    end
endmodule
